// ==== include/crb_pkg.sv ====
// Constants for the configuration register attribute bank
//
// Behaviour
// - Byte, word and dword accesses honour byte enables
// - Address port takes full dword accesses only
// - Lowest byte address holds least significant byte
// - Hard reset loads defaults except sticky bits
// - Sticky bits keep value across hard reset
// - Hardware-owned bits ignore software writes
// - Write trigger bits pulse, hold no state
// - Read/write bits store and return writes
// - Clear-on-read bits clear after a read
// - Clear-on-read writable bits also accept writes
// - Writing one clears, writing zero does nothing
// - Writing one sets, only hardware clears
// - Lockable bits ignore writes while locked
// - Single-write bits accept first write only
// - Single-write locking is tracked per bit
// - Unsupported restricted values leave field unchanged
// - Mechanism one decode, extended space, bus zero
// - Also reachable by memory ranges, JTAG, SMBus
// - Accesses below the hub forwarded downstream
// - Reserved locations read zero, writes ignored
// - Only power-ok reset clears sticky bits
// - Set lock bit makes lockable bits read-only
package crb_pkg;
  // ----------------------------------------
  // Bank geometry
  // ----------------------------------------
  localparam int NREG = 4;                        // Implemented dwords
  localparam int IDX_W = 2;                       // Dword index width
  localparam logic [9:0] NREG_DW = 10'h004;       // Dword count
  localparam logic [9:0] BANK_DW_BASE = 10'h010;  // First dword, byte 0x40
  localparam logic [3:0] BE_ALL = 4'hF;           // Full dword enables
  // ----------------------------------------
  // Access sources
  // ----------------------------------------
  localparam logic [1:0] SRC_IO = 2'h0;    // Port cycles
  localparam logic [1:0] SRC_MMIO = 2'h1;  // Memory cycles
  localparam logic [1:0] SRC_JTAG = 2'h2;  // JTAG sideband
  localparam logic [1:0] SRC_SMB = 2'h3;   // SMBus sideband
  // ----------------------------------------
  // Decode constants
  // ----------------------------------------
  localparam logic [15:0] IO_ADDR_PORT = 16'h0CF8;  // Address port
  localparam logic [15:0] IO_DATA_PORT = 16'h0CFC;  // Data port
  localparam logic [31:0] CA_WMASK = 32'h8FFF_FFFC; // Writable address bits
  localparam int CA_EN_BIT = 31;                    // Decode enable
  localparam logic [4:0] DEV_NUM = 5'h00;           // Own device number
  localparam logic [3:0] MMCFG_BASE = 4'hE;         // Extended window
  localparam logic [19:0] MMREG_BASE = 20'hFED00;   // Direct window
  localparam logic [31:0] NO_DEV_DATA = 32'hFFFF_FFFF; // Absent device
  // ----------------------------------------
  // Lock and restricted field
  // ----------------------------------------
  localparam int LOCK_REG = 0;               // Holds the lock bit
  localparam int LOCK_BIT = 31;              // Lock bit position
  localparam int RRW_REG = 3;                // Holds restricted field
  localparam int RRW_LSB = 0;                // Field position
  localparam logic [1:0] RRW_BAD = 2'h3;     // Unsupported encoding
  // ----------------------------------------
  // Attribute masks, index 3 first
  // ----------------------------------------
  localparam logic [NREG-1:0][31:0] RW_M = {32'hFFFF_FF00, 32'hFFFF_FF00, 32'h0, 32'hFF00_0000};
  localparam logic [NREG-1:0][31:0] RWL_M = {32'h0, 32'h0, 32'h0, 32'h00FF_0000};
  localparam logic [NREG-1:0][31:0] RWO_M = {32'h0, 32'h0, 32'h0, 32'h0000_FF00};
  localparam logic [NREG-1:0][31:0] RO_M = {32'h0, 32'h0, 32'h0, 32'h0000_00F0};
  localparam logic [NREG-1:0][31:0] WO_M = {32'h0, 32'h0, 32'h0, 32'h0000_000F};
  localparam logic [NREG-1:0][31:0] RC_M = {32'h0, 32'h0, 32'h0000_00FF, 32'h0};
  localparam logic [NREG-1:0][31:0] RCW_M = {32'h0, 32'h0, 32'h0000_FF00, 32'h0};
  localparam logic [NREG-1:0][31:0] W1C_M = {32'h0, 32'h0000_00FF, 32'h00FF_0000, 32'h0};
  localparam logic [NREG-1:0][31:0] W1S_M = {32'h0, 32'h0, 32'hFF00_0000, 32'h0};
  localparam logic [NREG-1:0][31:0] RRW_M = {32'h0000_0003, 32'h0, 32'h0, 32'h0};
  localparam logic [NREG-1:0][31:0] STK_M = {32'h0, 32'h0000_FFFF, 32'h0, 32'h0};
  localparam logic [NREG-1:0][31:0] DFLT = {32'h0000_0001, 32'h00A5_0000, 32'h0, 32'h0};

  // Byte enables to a bit mask, lane k is byte address k
  function automatic logic [31:0] be_to_mask(input logic [3:0] be);
    be_to_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction
endpackage

// ==== design/crb_dword.sv ====
// One dword of the bank with per-bit access attributes
`timescale 1ns/1ns
module crb_dword #(
  parameter logic [31:0] RW = 32'h0,   // Plain read/write
  parameter logic [31:0] LOCKABLE_BIT = 32'h0,  // Lockable
  parameter logic [31:0] SINGLE_WRITE_BIT = 32'h0,  // Single write
  parameter logic [31:0] RO = 32'h0,   // Hardware owned
  parameter logic [31:0] WO = 32'h0,   // Write trigger
  parameter logic [31:0] RC = 32'h0,   // Clear on read
  parameter logic [31:0] CLEAR_ON_READ_WRITABLE_BIT = 32'h0,  // Clear on read, writable
  parameter logic [31:0] W1C = 32'h0,  // Write one clear
  parameter logic [31:0] W1S = 32'h0,  // Write one set
  parameter logic [31:0] RESTRICTED_VALUE_BIT = 32'h0,  // Restricted value
  parameter logic [31:0] STK = 32'h0,  // Sticky
  parameter logic [31:0] DEF = 32'h0   // Default value
) (
  input wire logic clk_i,            // Core clock
  input wire logic arst_n_i,         // Hard reset, low
  input wire logic pwr_rst_n_i,      // Power-ok reset, low
  input wire logic wen_i,            // Write strobe
  input wire logic ren_i,            // Read strobe
  input wire logic [3:0] be_i,       // Byte enables
  input wire logic [31:0] wdata_i,   // Write data
  input wire logic rrw_ok_i,         // Restricted value legal
  input wire logic lock_i,           // Lock for lockable bits
  input wire logic [31:0] hw_val_i,  // Hardware-owned values
  input wire logic [31:0] hw_set_i,  // Hardware set events
  input wire logic [31:0] hw_clr_i,  // Hardware clears
  output logic [31:0] rdata_o,       // Read value
  output logic [31:0] q_o,           // Stored bits
  output logic [31:0] trig_o         // Trigger pulses
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  localparam logic [31:0] STORE = RW | LOCKABLE_BIT | SINGLE_WRITE_BIT | RC | CLEAR_ON_READ_WRITABLE_BIT | W1C | W1S | RESTRICTED_VALUE_BIT;
  localparam logic [31:0] STAT = RC | CLEAR_ON_READ_WRITABLE_BIT | W1C;
  logic [31:0] val_reg;   // Ordinary bits
  logic [31:0] stk_reg;   // Sticky bits
  logic [31:0] once_reg;  // Single-write bits used up
  logic [31:0] trig_reg;  // Trigger pulse
  logic [31:0] next;
  wire rst_any_n = arst_n_i & pwr_rst_n_i;  // Power-ok implies hard
  wire [31:0] bm = crb_pkg::be_to_mask(be_i);
  wire [31:0] wr = {32{wen_i}} & bm;
  wire [31:0] rd = {32{ren_i}} & bm;
  wire [31:0] set = hw_set_i & STAT;
  wire [31:0] q = ((val_reg & ~STK) | (stk_reg & STK)) & STORE;
  wire [31:0] wr_l = wr & {32{~lock_i}};
  wire [31:0] wr_o = wr & ~once_reg;
  wire [31:0] wr_r = wr & {32{rrw_ok_i}};

  // Per-attribute next values, hardware set is ORed into each status term so it wins
  always_comb begin
    next = RW & ((wr & wdata_i) | (~wr & q));
    next |= LOCKABLE_BIT & ((wr_l & wdata_i) | (~wr_l & q));
    next |= SINGLE_WRITE_BIT & ((wr_o & wdata_i) | (~wr_o & q));
    next |= RESTRICTED_VALUE_BIT & ((wr_r & wdata_i) | (~wr_r & q));
    next |= RC & (set | (q & ~rd));
    next |= CLEAR_ON_READ_WRITABLE_BIT & (set | (wr & wdata_i) | (~wr & q & ~rd));
    next |= W1C & (set | (q & ~(wr & wdata_i)));
    next |= W1S & ((wr & wdata_i) | (q & ~hw_clr_i));
  end

  // Ordinary bits return to defaults on either reset
  always_ff @(posedge clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      val_reg <= DEF;
      once_reg <= 32'h0;
      trig_reg <= 32'h0;
    end else begin
      val_reg <= next & ~STK;
      once_reg <= once_reg | (wr & SINGLE_WRITE_BIT);
      trig_reg <= wr & wdata_i & WO;
    end
  end

  // Sticky bits see only the power-ok reset
  always_ff @(posedge clk_i or negedge pwr_rst_n_i) begin
    if (!pwr_rst_n_i) begin
      stk_reg <= DEF & STK;
    end else begin
      stk_reg <= next & STK;
    end
  end

  // Trigger bits read as zero, hardware bits pass through
  assign rdata_o = q | (hw_val_i & RO);
  assign q_o = q;
  assign trig_o = trig_reg;
endmodule

// ==== design/crb_top.sv ====
// Access decode and register bank for the configuration space
`timescale 1ns/1ns
module crb_top (
  input wire logic clk_i,                           // Core clock
  input wire logic arst_n_i,                        // Hard reset, low
  input wire logic pwr_ok_rst_n_i,                  // Power-ok reset, low
  input wire logic req_i,                           // Access request
  input wire logic we_i,                            // Write when high
  input wire logic [1:0] src_i,                     // Access source
  input wire logic [31:0] addr_i,                   // Port, memory or config address
  input wire logic [3:0] be_i,                      // Byte enables
  input wire logic [31:0] wdata_i,                  // Write data
  output logic ack_o,                               // Access done
  output logic [31:0] rdata_o,                      // Read data
  output logic fwd_req_o,                           // Downstream request
  output logic fwd_we_o,                            // Downstream write
  output logic [25:0] fwd_addr_o,                   // Bus, dev, fn, dword
  output logic [3:0] fwd_be_o,                      // Downstream enables
  output logic [31:0] fwd_wdata_o,                  // Downstream data
  input wire logic fwd_ack_i,                       // Downstream done
  input wire logic [31:0] fwd_rdata_i,              // Downstream read data
  input wire logic [crb_pkg::NREG-1:0][31:0] hw_val_i, // Hardware-owned values
  input wire logic [crb_pkg::NREG-1:0][31:0] hw_set_i, // Hardware set events
  input wire logic [crb_pkg::NREG-1:0][31:0] hw_clr_i, // Hardware clears
  input wire logic hw_lock_i,                       // Hardware lock
  output logic [crb_pkg::NREG-1:0][31:0] cfg_o,     // Stored bits
  output logic [crb_pkg::NREG-1:0][31:0] trig_o     // Trigger pulses
);
  // ----------------------------------------
  // Access sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,  // Ready for a request
    ST_FWD = 3'b010,   // Waiting on downstream
    ST_RESP = 3'b100   // Answer on the ports
  } crb_state_e;

  crb_state_e state_reg;       // Current state
  crb_state_e state_next;      // Next state
  logic [31:0] cfg_addr_reg;   // Address port contents
  logic [31:0] rdata_reg;      // Answer data
  logic fwd_we_reg;            // Held downstream write flag
  logic [25:0] fwd_addr_reg;   // Held downstream address
  logic [3:0] fwd_be_reg;      // Held downstream enables
  logic [31:0] fwd_wdata_reg;  // Held downstream data

  // Power-ok reset acts as a hard reset too
  wire rst_any_n = arst_n_i & pwr_ok_rst_n_i;

  // ----------------------------------------
  // Restricted field legality
  // ----------------------------------------
  // Field is judged on its own two bits of the written data
  function automatic logic rrw_legal(input logic [31:0] d);
    rrw_legal = (d[crb_pkg::RRW_LSB +: 2] != crb_pkg::RRW_BAD);
  endfunction

  // ----------------------------------------
  // Source and window decode
  // ----------------------------------------
  wire take = req_i && (state_reg == ST_IDLE);
  wire is_io = (src_i == crb_pkg::SRC_IO);
  wire is_mm = (src_i == crb_pkg::SRC_MMIO);
  // Sideband paths carry the address-port format directly
  wire is_sb = (src_i == crb_pkg::SRC_JTAG) || (src_i == crb_pkg::SRC_SMB);
  wire [15:0] io_port = {addr_i[15:2], 2'h0};
  wire io_addr_hit = is_io && (io_port == crb_pkg::IO_ADDR_PORT);
  // Narrow cycles to the address port fall through untouched
  wire io_addr_full = io_addr_hit && (be_i == crb_pkg::BE_ALL);
  wire io_data_hit = is_io && (io_port == crb_pkg::IO_DATA_PORT)
    && cfg_addr_reg[crb_pkg::CA_EN_BIT];
  wire mm_cfg_hit = is_mm && (addr_i[31:28] == crb_pkg::MMCFG_BASE);
  wire mm_reg_hit = is_mm && (addr_i[31:12] == crb_pkg::MMREG_BASE);
  wire mm_hit = mm_cfg_hit || mm_reg_hit;
  wire [31:0] ca_word = is_io ? cfg_addr_reg : addr_i;

  // ----------------------------------------
  // Target fields
  // ----------------------------------------
  // Direct window always lands on this device, bus zero
  wire [7:0] ca_bus = ca_word[23:16];
  wire [4:0] ca_dev = ca_word[15:11];
  wire [2:0] ca_fn = ca_word[10:8];
  // Upper dword bits come from the extended field
  wire [9:0] ca_dw = {ca_word[27:24], ca_word[7:2]};
  wire [7:0] tgt_bus = mm_reg_hit ? 8'h00 : (mm_cfg_hit ? addr_i[27:20] : ca_bus);
  wire [4:0] tgt_dev = mm_reg_hit ? crb_pkg::DEV_NUM : (mm_cfg_hit ? addr_i[19:15] : ca_dev);
  wire [2:0] tgt_fn = mm_reg_hit ? 3'h0 : (mm_cfg_hit ? addr_i[14:12] : ca_fn);
  wire [9:0] tgt_dw = mm_hit ? addr_i[11:2] : ca_dw;
  wire tgt_hit = io_data_hit || mm_hit || is_sb;

  // ----------------------------------------
  // Target classes
  // ----------------------------------------
  wire tgt_local = tgt_hit && (tgt_bus == 8'h00) && (tgt_dev == crb_pkg::DEV_NUM)
    && (tgt_fn == 3'h0);
  wire tgt_absent = tgt_hit && (tgt_bus == 8'h00) && !tgt_local;
  wire tgt_down = tgt_hit && (tgt_bus != 8'h00);
  wire [9:0] bank_off = tgt_dw - crb_pkg::BANK_DW_BASE;
  // Anything else in the local space is reserved
  wire in_bank = (tgt_dw >= crb_pkg::BANK_DW_BASE) && (bank_off < crb_pkg::NREG_DW);
  wire [crb_pkg::IDX_W-1:0] bank_idx = bank_off[crb_pkg::IDX_W-1:0];
  wire bank_acc = take && tgt_local && in_bank;

  // ----------------------------------------
  // Register bank
  // ----------------------------------------
  logic [crb_pkg::NREG-1:0] wen;                // Per-dword write
  logic [crb_pkg::NREG-1:0] ren;                // Per-dword read
  logic [crb_pkg::NREG-1:0][31:0] bank_rd;     // Per-dword read value
  logic [crb_pkg::NREG-1:0][31:0] bank_q;      // Per-dword stored bits
  // Lock bit lives in the bank itself, hardware may force it
  wire lock_now = hw_lock_i || bank_q[crb_pkg::LOCK_REG][crb_pkg::LOCK_BIT];

  genvar g;
  generate
    for (g = 0; g < crb_pkg::NREG; g = g + 1) begin : g_dw
      // Strobes only on the taking edge, lanes from byte enables
      assign wen[g] = bank_acc && we_i && (bank_idx == crb_pkg::IDX_W'(g));
      assign ren[g] = bank_acc && !we_i && (bank_idx == crb_pkg::IDX_W'(g));
      crb_dword #(
        .RW(crb_pkg::RW_M[g]),
        .LOCKABLE_BIT(crb_pkg::RWL_M[g]),
        .SINGLE_WRITE_BIT(crb_pkg::RWO_M[g]),
        .RO(crb_pkg::RO_M[g]),
        .WO(crb_pkg::WO_M[g]),
        .RC(crb_pkg::RC_M[g]),
        .CLEAR_ON_READ_WRITABLE_BIT(crb_pkg::RCW_M[g]),
        .W1C(crb_pkg::W1C_M[g]),
        .W1S(crb_pkg::W1S_M[g]),
        .RESTRICTED_VALUE_BIT(crb_pkg::RRW_M[g]),
        .STK(crb_pkg::STK_M[g]),
        .DEF(crb_pkg::DFLT[g])
      ) u_dw (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pwr_rst_n_i(pwr_ok_rst_n_i),
        .wen_i(wen[g]),
        .ren_i(ren[g]),
        .be_i(be_i),
        .wdata_i(wdata_i),
        .rrw_ok_i(rrw_legal(wdata_i)),
        .lock_i(lock_now),
        .hw_val_i(hw_val_i[g]),
        .hw_set_i(hw_set_i[g]),
        .hw_clr_i(hw_clr_i[g]),
        .rdata_o(bank_rd[g]),
        .q_o(bank_q[g]),
        .trig_o(trig_o[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Answer data selection
  // ----------------------------------------
  // Reserved and unclaimed reads give zero, absent devices all ones
  wire [31:0] rd_local = in_bank ? bank_rd[bank_idx] : 32'h0;
  wire [31:0] rd_sel = io_addr_full ? cfg_addr_reg
    : (tgt_local ? rd_local : (tgt_absent ? crb_pkg::NO_DEV_DATA : 32'h0));
  wire [31:0] rd_next = we_i ? 32'h0 : rd_sel;
  wire [31:0] fwd_rd = fwd_we_reg ? 32'h0 : fwd_rdata_i;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // One request at a time; downstream stalls the sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (take && tgt_down) begin
          state_next = ST_FWD;
        end else if (take) begin
          state_next = ST_RESP;
        end
      end
      ST_FWD: begin
        if (fwd_ack_i) begin
          state_next = ST_RESP;
        end
      end
      ST_RESP: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address port, full dword writes only, reserved bits kept zero
  always_ff @(posedge clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      cfg_addr_reg <= 32'h0;
    end else if (take && io_addr_full && we_i) begin
      cfg_addr_reg <= wdata_i & crb_pkg::CA_WMASK;
    end
  end

  // Answer data, from the bank or from downstream
  always_ff @(posedge clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      rdata_reg <= 32'h0;
    end else if (take && !tgt_down) begin
      rdata_reg <= rd_next;
    end else if (state_reg == ST_FWD && fwd_ack_i) begin
      rdata_reg <= fwd_rd;
    end
  end

  // Downstream request fields held while waiting
  always_ff @(posedge clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      fwd_we_reg <= 1'b0;
      fwd_addr_reg <= 26'h0;
      fwd_be_reg <= 4'h0;
      fwd_wdata_reg <= 32'h0;
    end else if (take && tgt_down) begin
      fwd_we_reg <= we_i;
      fwd_addr_reg <= {tgt_bus, tgt_dev, tgt_fn, tgt_dw};
      fwd_be_reg <= be_i;
      fwd_wdata_reg <= wdata_i;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign ack_o = (state_reg == ST_RESP);
  assign rdata_o = rdata_reg;
  assign fwd_req_o = (state_reg == ST_FWD);
  assign fwd_we_o = fwd_we_reg;
  assign fwd_addr_o = fwd_addr_reg;
  assign fwd_be_o = fwd_be_reg;
  assign fwd_wdata_o = fwd_wdata_reg;
  assign cfg_o = bank_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_any_n);

  // Helper values for the checks
  wire [31:0] acc_bits = crb_pkg::be_to_mask(be_i);
  wire [31:0] wr_bits = wdata_i & acc_bits;
  logic [31:0] once_seen_reg;  // Single-write bits already written

  // Tracks which single-write bits were used
  always_ff @(posedge clk_i or negedge rst_any_n) begin
    if (!rst_any_n) begin
      once_seen_reg <= 32'h0;
    end else if (wen[0]) begin
      once_seen_reg <= once_seen_reg | (acc_bits & crb_pkg::RWO_M[0]);
    end
  end

  sequence s_take_local;
    take && tgt_local;
  endsequence

  sequence s_take_down;
    take && tgt_down;
  endsequence

  sequence s_fwd_wait;
    fwd_req_o && !fwd_ack_i;
  endsequence

  chk_local_ack: assert property (s_take_local |=> ack_o ##1 !ack_o)
    else $error("local access not answered in one cycle");

  chk_fwd_start: assert property (s_take_down |=> fwd_req_o && !ack_o)
    else $error("downstream access not forwarded");

  chk_fwd_hold: assert property (s_fwd_wait |=> fwd_req_o && $stable(fwd_addr_o))
    else $error("downstream request dropped early");

  chk_addr_narrow: assert property (take && io_addr_hit && we_i
    && be_i != crb_pkg::BE_ALL |=> $stable(cfg_addr_reg))
    else $error("narrow write changed address port");

  chk_rsvd_zero: assert property (s_take_local ##0 (!in_bank && !we_i)
    |=> ack_o && rdata_o == 32'h0)
    else $error("reserved read not zero");

  chk_set_wins: assert property ((|hw_set_i[1])
    |=> (bank_q[1] & $past(hw_set_i[1]) & crb_pkg::W1C_M[1])
    == ($past(hw_set_i[1]) & crb_pkg::W1C_M[1]))
    else $error("hardware set lost");

  chk_w1c_clear: assert property (wen[1] && hw_set_i[1] == 32'h0
    |=> (bank_q[1] & $past(wr_bits) & crb_pkg::W1C_M[1]) == 32'h0)
    else $error("write one did not clear");

  chk_w1s_set: assert property (wen[1]
    |=> (bank_q[1] & $past(wr_bits) & crb_pkg::W1S_M[1])
    == ($past(wr_bits) & crb_pkg::W1S_M[1]))
    else $error("write one did not set");

  chk_rc_clear: assert property (ren[1] && hw_set_i[1] == 32'h0
    |=> (bank_q[1] & $past(acc_bits) & crb_pkg::RC_M[1]) == 32'h0)
    else $error("read did not clear");

  // A hardware set on an unread byte is a legal change, so it is left out
  chk_rc_bytes: assert property (ren[1] && hw_set_i[1] == 32'h0
    |=> ((bank_q[1] ^ $past(bank_q[1])) & ~$past(acc_bits) & crb_pkg::RC_M[1]) == 32'h0)
    else $error("read cleared an unread byte");

  chk_lock_hold: assert property (wen[0] && lock_now
    |=> ((bank_q[0] ^ $past(bank_q[0])) & crb_pkg::RWL_M[0]) == 32'h0)
    else $error("locked bit changed");

  chk_once_keep: assert property (wen[0]
    |=> ((bank_q[0] ^ $past(bank_q[0])) & $past(once_seen_reg)) == 32'h0)
    else $error("single-write bit rewritten");

  chk_rrw_keep: assert property (wen[3] && !rrw_legal(wdata_i)
    |=> ((bank_q[3] ^ $past(bank_q[3])) & crb_pkg::RRW_M[3]) == 32'h0)
    else $error("unsupported value stored");

  // Clear-on-read bits must not lose an event that meets a read
  chk_rc_set_wins: assert property ((|(hw_set_i[1] & crb_pkg::RC_M[1]))
    |=> (bank_q[1] & $past(hw_set_i[1]) & crb_pkg::RC_M[1])
    == ($past(hw_set_i[1]) & crb_pkg::RC_M[1]))
    else $error("hardware set lost on read");

  // Trigger bits pulse once for written ones and stay quiet otherwise
  chk_trig_pulse: assert property (wen[0]
    |=> trig_o[0] == ($past(wr_bits) & crb_pkg::WO_M[0]))
    else $error("trigger pulse wrong");

  chk_trig_quiet: assert property (!wen[0] |=> trig_o[0] == 32'h0)
    else $error("trigger pulse without write");

  chk_fwd_done: assert property (fwd_req_o && fwd_ack_i |=> ack_o && !fwd_req_o)
    else $error("downstream answer not passed on");
endmodule

// ==== test/crb_fwd_model.sv ====
// Downstream responder model for forwarded configuration cycles
`timescale 1ns/1ns
module crb_fwd_model (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Reset, low
  input wire logic req_i, // Forward request
  input wire logic [25:0] addr_i, // Bus, dev, fn, dword
  input wire logic [3:0] wait_i, // Answer delay
  output logic ack_o, // Answer pulse
  output logic [31:0] rdata_o // Read data
);
  logic [3:0] cnt_reg; // Wait count
  wire go = req_i && !ack_o && cnt_reg == wait_i; // Answer now
  // Data toggles off the answer cycle so stale values never match
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      cnt_reg <= 4'h0;
      rdata_o <= 32'h0;
    end else begin
      ack_o <= go;
      cnt_reg <= (req_i && !go && !ack_o) ? cnt_reg + 4'h1 : 4'h0;
      rdata_o <= go ? {6'h2A, addr_i} : ~rdata_o;
    end
  end
endmodule

// ==== test/tb_top.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
module tb_top;
  logic clk_i = 1'b0, arst_n_i = 1'b0, pwr_ok_rst_n_i = 1'b0, req_i = 1'b0, we_i = 1'b0;
  logic hw_lock_i = 1'b0, ack_o, fwd_req_o, fwd_ack_i;
  logic [1:0] src_i = 2'h0;
  logic [3:0] be_i = 4'h0, dly = 4'h3;
  logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, rdata_o, fwd_rdata_i, rd, tg;
  logic [25:0] fwd_addr_o;
  logic fwd_we_o;
  logic [3:0] fwd_be_o;
  logic [31:0] fwd_wdata_o, fw_d;
  logic [4:0] fw_c;
  logic [3:0][31:0] hw_val_i = {4{32'hC0}}, hw_set_i = '0, hw_clr_i = '0, cfg_o, trig_o;
  int n_errors = 0, total_checks = 0;
  always #4 clk_i = ~clk_i;
  crb_top dut_u (.clk_i, .arst_n_i, .pwr_ok_rst_n_i, .req_i, .we_i, .src_i, .addr_i, .be_i,
    .wdata_i, .ack_o, .rdata_o, .fwd_req_o, .fwd_we_o, .fwd_addr_o, .fwd_be_o,
    .fwd_wdata_o, .fwd_ack_i, .fwd_rdata_i, .hw_val_i, .hw_set_i, .hw_clr_i, .hw_lock_i,
    .cfg_o, .trig_o);
  crb_fwd_model fwd_u (.clk_i, .rst_n_i(arst_n_i), .req_i(fwd_req_o), .addr_i(fwd_addr_o),
    .wait_i(dly), .ack_o(fwd_ack_i), .rdata_o(fwd_rdata_i));
  // Forwarded request fields, caught while the request stands
  always @(posedge clk_i) begin
    if (fwd_req_o) begin
      fw_c <= {fwd_we_o, fwd_be_o};
      fw_d <= fwd_wdata_o;
    end
  end
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until the answer is sampled; bounded wait
  task automatic acc(input logic [1:0] s, input logic w, input logic [31:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    int n = 0;
    src_i <= s;
    we_i <= w;
    addr_i <= a;
    be_i <= b;
    wdata_i <= d;
    req_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    rd = rdata_o;
    tg = trig_o[0];
    req_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [31:0] a, input logic [3:0] b, input logic [31:0] d);
    acc(2'h2, 1'b1, a, b, d);
  endtask
  task automatic rdc(input logic [31:0] a, e);
    acc(2'h3, 1'b0, a, 4'hF, 32'h0);
    chk(rd, e);
  endtask
  task automatic rst(input logic p);
    arst_n_i <= 1'b0;
    pwr_ok_rst_n_i <= !p;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    pwr_ok_rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  task automatic t_bytes;
    rdc(32'h48, 32'h00A5_0000);
    wr(32'h4C, 4'h2, 32'h0000_AB03);
    rdc(32'h4C, 32'h0000_AB01);
    wr(32'h4C, 4'h9, 32'h1200_0003);
    rdc(32'h4C, 32'h1200_AB01);
    wr(32'h4C, 4'h1, 32'h0000_0002);
    chk(cfg_o[3], 32'h1200_AB02);
  endtask
  task automatic t_attr;
    wr(32'h40, 4'h3, 32'h0000_055A);
    chk(tg, 32'h0000_000A);
    wr(32'h40, 4'h6, 32'h0011_FF00);
    wr(32'h40, 4'h8, 32'h8000_0000);
    wr(32'h40, 4'h4, 32'h0033_0000);
    rdc(32'h40, 32'h8011_05C0);
  endtask
  task automatic t_status;
    hw_set_i[1] <= 32'h00FF_00FF;
    @(posedge clk_i);
    hw_set_i[1] <= 32'h0;
    acc(2'h1, 1'b0, 32'hFED0_0044, 4'h2, 32'h0);
    chk(rd, 32'h00FF_00FF);
    rdc(32'h44, 32'h00FF_00FF);
    wr(32'h44, 4'hE, 32'h030F_5A00);
    rdc(32'h44, 32'h03F0_5A00);
    rdc(32'h44, 32'h03F0_0000);
    // Hardware set and write-one clear meet at the taking edge
    hw_set_i[1] <= 32'h0001_0000;
    fork
      wr(32'h44, 4'h4, 32'h0001_0000);
      begin
        @(posedge clk_i);
        hw_set_i[1] <= 32'h0;
      end
    join
    hw_clr_i[1] <= 32'h0100_0000;
    @(posedge clk_i);
    hw_clr_i[1] <= 32'h0;
    rdc(32'h44, 32'h02F1_0000);
  endtask
  task automatic t_sticky;
    wr(32'h48, 4'hF, 32'h1234_3C00);
    rst(1'b0);
    rdc(32'h48, 32'h00A5_3C00);
    rst(1'b1);
    rdc(32'h48, 32'h00A5_0000);
    hw_lock_i <= 1'b1;
    wr(32'h40, 4'h4, 32'h0077_0000);
    hw_lock_i <= 1'b0;
    rdc(32'h40, 32'h0000_00C0);
  endtask
  task automatic t_route;
    acc(2'h0, 1'b1, 32'hCF8, 4'hF, 32'h8000_004C);
    acc(2'h0, 1'b1, 32'hCF8, 4'h1, 32'h0);
    acc(2'h0, 1'b0, 32'hCFC, 4'hF, 32'h0);
    chk(rd, 32'h0000_0001);
    rdc(32'h0840, 32'hFFFF_FFFF);
    rdc(32'h0050, 32'h0);
    acc(2'h1, 1'b0, 32'hE000_0048, 4'hF, 32'h0);
    chk(rd, 32'h00A5_0000);
  endtask
  task automatic t_fwd;
    wr(32'h0001_0040, 4'h5, 32'h1234_5678);
    chk(rd, 32'h0);
    chk(fw_d, 32'h1234_5678);
    chk({27'h0, fw_c}, 32'h0000_0015);
    dly <= 4'h0;
    rdc(32'h0201_0044, 32'hA804_0091);
    chk({27'h0, fw_c}, 32'h0000_000F);
  endtask
  initial begin
    rst(1'b1);
    t_bytes();
    t_attr();
    t_status();
    t_sticky();
    t_route();
    t_fwd();
    end_of_test();
  end
  // Whole run is a little over a hundred cycles
  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end
endmodule
